// ---- bench/i2c_bus_master_model.sv ----
// Behavioural two-wire bus master clocking bytes into the slave.
// Assumes pull-ups on both lines; an output high pulls that line low.
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_master_model (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output var  logic o_scl_low,
  output var  logic o_sda_low
);
  // Idle bus at time zero
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // Release SCL and wait while a slave stretches it
  task automatic scl_high;
    o_scl_low = 1'b0;
    for (int n = 0; n < 20000 && i_scl !== 1'b1; n++) #4;
  endtask
  // Start or Restart; 1 ns offset keeps pin edges off the system clock edge
  task automatic start;
    #1 o_sda_low = 1'b0;
    #40 scl_high;
    #40 o_sda_low = 1'b1;
    #40 o_scl_low = 1'b1;
    #40;
  endtask
  // Stop after a clock low period
  task automatic stop;
    #1 o_sda_low = 1'b1;
    #40 scl_high;
    #40 o_sda_low = 1'b0;
    #80;
  endtask
  // SDA dips and recovers with SCL high throughout
  task automatic glitch;
    #1 o_sda_low = 1'b1;
    #40 o_sda_low = 1'b0;
    #40;
  endtask
  // Data set in the low half, sampled in the middle of the high half
  task automatic put_bit(input logic b, output logic r);
    #1 o_sda_low = !b;
    #40 scl_high;
    #40 r = i_sda;
    #40 o_scl_low = 1'b1;
    #40;
  endtask
  // MSB first; SDA released in the ninth slot for the acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, ack);
  endtask
endmodule
`default_nettype wire

// ---- bench/i2c_slave_checker_assertions.sv ----
// Timing checks on the slave receiver's pins and status flags.
// Assumes it is bound to the top module; SCL and SDA are resolved wire levels.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_slave_consts.vh"
module i2c_slave_checker (
  input wire logic               i_ref_clk,
  input wire logic               i_srst,
  input wire logic               i_scl,
  input wire logic               i_sda,
  input wire logic [`MODE_W-1:0] i_port_mode_select,
  input wire logic               i_address_hold_enable,
  input wire logic               i_data_hold_enable,
  input wire logic               i_ack_value_select,
  input wire logic               i_buffer_overwrite_enable,
  input wire logic               i_address_write,
  input wire logic               o_scl_out,
  input wire logic               o_sda_out,
  input wire logic               o_scl_oe,
  input wire logic               o_sda_oe,
  input wire logic               o_buffer_full,
  input wire logic               o_receive_overflow,
  input wire logic               o_read_write,
  input wire logic               o_start_seen,
  input wire logic               o_stop_seen,
  input wire logic               o_ack_time_flag,
  input wire logic               o_update_address_flag,
  input wire logic               o_clock_release
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  logic low_reg;
  // SCL low seen since the last Start; a Stop without one is only a glitch
  always @(posedge i_ref_clk) begin
    if (i_srst || (i_scl && $fell(i_sda)))
      low_reg <= 1'b0;
    else if (!i_scl)
      low_reg <= 1'b1;
  end
  sequence s_start; i_scl && $fell(i_sda); endsequence
  sequence s_stop; i_scl && $rose(i_sda) && low_reg; endsequence
  property p_start; s_start |-> ##[2:8] o_start_seen; endproperty
  a_start: assert property (p_start) else $error("start not flagged");
  property p_stop; s_stop |-> ##[2:8] o_stop_seen; endproperty
  a_stop: assert property (p_stop) else $error("stop not flagged");
  property p_glitch; i_scl && $rose(i_sda) && !low_reg |-> ##1 !o_stop_seen [*8]; endproperty
  a_glitch: assert property (p_glitch) else $error("stop taken without clock low");
  property p_start_clr; $rose(o_start_seen) |-> !o_stop_seen; endproperty
  a_start_clr: assert property (p_start_clr) else $error("stop flag kept");
  property p_stop_clr; $rose(o_stop_seen) |-> !o_start_seen; endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("start flag kept");
  property p_pins; !o_scl_out && !o_sda_out; endproperty
  a_pins: assert property (p_pins) else $error("pin driven high");
  property p_hold; !o_clock_release [*2] |-> o_scl_oe; endproperty
  a_hold: assert property (p_hold) else $error("clock not held");
  property p_acktime;
    $rose(o_ack_time_flag) |-> i_address_hold_enable || i_data_hold_enable;
  endproperty
  a_acktime: assert property (p_acktime) else $error("ack time without hold");
  property p_ovf; $rose(o_receive_overflow) |-> $past(o_buffer_full); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow with empty buffer");
  property p_nack;
    $rose(o_sda_oe) && !o_read_write && o_receive_overflow |-> i_buffer_overwrite_enable;
  endproperty
  a_nack: assert property (p_nack) else $error("ack during overflow");
  property p_ackval; $rose(o_sda_oe) && o_ack_time_flag |-> !i_ack_value_select; endproperty
  a_ackval: assert property (p_ackval) else $error("ack against ack value");
  property p_ua; $rose(o_update_address_flag) |-> i_port_mode_select[`MODE_TEN_BIT_BIT];
  endproperty
  a_ua: assert property (p_ua) else $error("update flag in 7-bit mode");
  property p_ua_hold; o_update_address_flag [*2] |-> o_scl_oe; endproperty
  a_ua_hold: assert property (p_ua_hold) else $error("clock free during update");
  property p_ua_clr; i_address_write && o_update_address_flag |=> !o_update_address_flag;
  endproperty
  a_ua_clr: assert property (p_ua_clr) else $error("update flag not cleared");
endmodule
bind i2c_slave_addr_receive i2c_slave_checker u_checker (
  .i_ref_clk, .i_srst, .i_scl, .i_sda, .i_port_mode_select, .i_address_hold_enable,
  .i_data_hold_enable, .i_ack_value_select, .i_buffer_overwrite_enable, .i_address_write,
  .o_scl_out, .o_sda_out, .o_scl_oe, .o_sda_oe, .o_buffer_full, .o_receive_overflow,
  .o_read_write, .o_start_seen, .o_stop_seen, .o_ack_time_flag, .o_update_address_flag,
  .o_clock_release
);
`default_nettype wire

// ---- bench/test_i2c_slave_addr_receive.sv ----
// Self-checking bench for the slave receiver driven by a bus master model.
// Assumes the design, the master model and the checker compile ahead of it.
`timescale 1ns/100ps
`default_nettype none
module test_i2c_slave_addr_receive;
  logic       clk, srst, aw, stretch_enable, rel, ah, dh, akv, boe, sie, brd, iclr, oclr, ack;
  logic [1:0] mode;
  logic [7:0] adr;
  int         num_errors, check_count;
  wire        scl, sda, m_scl_low, m_sda_low, scl_out, scl_oe, sda_out, sda_oe;
  wire  [7:0] buff;
  wire        bf, ovf, rw, dna, st, sp, akr, akt, ua, cr, irq, col, pm;
  // Open-drain lines with pull-ups
  assign scl = !(m_scl_low || scl_oe);
  assign sda = !(m_sda_low || sda_oe);
  i2c_bus_master_model m (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl_low),
    .o_sda_low(m_sda_low));
  i2c_slave_addr_receive dut (.i_ref_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda),
    .i_port_mode_select(mode), .i_slave_address(adr), .i_address_write(aw),
    .i_stretch_enable(stretch_enable), .i_clock_release(rel), .i_address_hold_enable(ah),
    .i_data_hold_enable(dh), .i_ack_value_select(akv), .i_buffer_overwrite_enable(boe),
    .i_start_irq_enable(sie), .i_stop_irq_enable(sie), .i_buffer_read(brd),
    .i_irq_clear(iclr), .i_overflow_clear(oclr), .i_collision_clear(1'b0),
    .i_tx_load(1'b0), .i_tx_data(8'h00), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_rx_tx_buffer(buff), .o_buffer_full(bf),
    .o_receive_overflow(ovf), .o_read_write(rw), .o_data_not_address(dna),
    .o_start_seen(st), .o_stop_seen(sp), .o_ack_received(akr), .o_ack_time_flag(akt),
    .o_update_address_flag(ua), .o_clock_release(cr), .o_port_irq_flag(irq),
    .o_bus_collision(col), .o_prior_match(pm));
  // 250 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Software side: read buffer, clear interrupt and overflow
  task automatic sw_clear;
    @(posedge clk) begin brd <= 1'b1; iclr <= 1'b1; oclr <= 1'b1; end
    @(posedge clk) begin brd <= 1'b0; iclr <= 1'b0; oclr <= 1'b0; end
  endtask
  task automatic pulse_rel;
    @(posedge clk) rel <= 1'b1;
    @(posedge clk) rel <= 1'b0;
  endtask
  task automatic set_addr(input logic [7:0] a);
    @(posedge clk) begin adr <= a; aw <= 1'b1; end
    @(posedge clk) aw <= 1'b0;
    @(posedge clk);
  endtask
  // Byte under address hold: software picks the acknowledge, then frees SCL
  task automatic hold_byte(input logic [7:0] d);
    fork
      m.wr_byte(d, ack);
      begin
        for (int n = 0; n < 1000 && akt !== 1'b1; n++) @(posedge clk);
        @(negedge clk);
        check({akt, cr, irq}, 3'b101);
        sw_clear;
        pulse_rel;
      end
    join
  endtask
  task automatic t_write7;
    @(posedge clk) begin adr <= 8'ha4; sie <= 1'b1; end
    m.start();
    check({st, sp, irq}, 3'b101);
    sw_clear;
    m.wr_byte(8'ha4, ack);
    check({ack, rw, dna, bf, irq}, 5'b00011);
    check(buff, 8'ha4);
    sw_clear;
    m.wr_byte(8'h5a, ack);
    check({ack, dna, buff}, {2'b01, 8'h5a});
    m.wr_byte(8'h3c, ack);
    check({ack, ovf, buff}, {2'b11, 8'h5a});
    sw_clear;
    m.stop();
    check({st, sp, irq}, 3'b011);
  endtask
  task automatic t_mismatch;
    @(posedge clk) adr <= 8'ha5;
    m.start();
    sw_clear;
    m.wr_byte(8'h42, ack);
    check({ack, bf, irq}, 3'b100);
    m.start();
    m.wr_byte(8'ha4, ack);
    check({ack, bf}, 2'b01);
    m.stop();
    m.glitch();
    sw_clear;
    check({st, sp}, 2'b10);
  endtask
  task automatic t_holds;
    @(posedge clk) begin ah <= 1'b1; akv <= 1'b1; sie <= 1'b0; end
    m.start();
    hold_byte(8'ha4);
    check({ack, akt}, 2'b10);
    @(posedge clk) akv <= 1'b0;
    m.start();
    hold_byte(8'ha4);
    check(ack, 1'b0);
    @(posedge clk) ah <= 1'b0;
    m.stop();
  endtask
  task automatic t_stretch;
    @(posedge clk) stretch_enable <= 1'b1;
    m.start();
    m.wr_byte(8'ha4, ack);
    check({cr, scl_oe}, 2'b01);
    sw_clear;
    fork
      m.wr_byte(8'h77, ack);
      pulse_rel;
    join
    check({ack, buff}, {1'b0, 8'h77});
    fork
      m.stop();
      pulse_rel;
    join
    @(posedge clk) stretch_enable <= 1'b0;
  endtask
  task automatic t_ten;
    @(posedge clk) mode <= 2'b11;
    sw_clear;
    set_addr(8'h06);
    m.start();
    check(irq, 1'b1);
    sw_clear;
    m.wr_byte(8'hf6, ack);
    check({ack, ua, scl_oe}, 3'b011);
    set_addr(8'h3c);
    check(ua, 1'b0);
    sw_clear;
    m.wr_byte(8'h3c, ack);
    check({ack, ua, pm}, 3'b011);
    set_addr(8'h06);
    sw_clear;
    m.wr_byte(8'h11, ack);
    check({ack, buff}, {1'b0, 8'h11});
    sw_clear;
    m.stop();
    check({pm, irq, sp}, 3'b011);
  endtask
  // Main sequence
  initial begin
    {srst, aw, stretch_enable, rel, ah, dh, akv, boe, sie, brd, iclr, oclr} = 12'h800;
    mode = 2'b00;
    adr = 8'h00;
    num_errors = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({scl_oe, sda_oe, bf, irq, ua, pm, cr}, 7'h01);
    t_write7;
    t_mismatch;
    t_holds;
    t_stretch;
    t_ten;
    report_and_stop;
  end
  // Watchdog: the full sequence needs well under 60 us
  initial begin
    #200000;
    num_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// ---- src/addr_match.v ----
// Address comparison for a received byte against the slave address.
// Purely combinational; the caller picks which result applies in each phase.
`timescale 1ns/100ps
`default_nettype none

`include "i2c_slave_consts.vh"

module addr_match (
  input  wire [7:0] i_byte,
  input  wire [7:0] i_address,
  output wire       o_match_7bit,
  output wire       o_match_high,
  output wire       o_match_low,
  output wire       o_read
);

  // Direction bit is the byte's least significant bit
  assign o_read       = i_byte[0];
  assign o_match_7bit = (i_byte[7:1] == i_address[7:1]);
  assign o_match_high = (i_byte[7:3] == `TEN_BIT_PATTERN) &&
                        (i_byte[2:1] == i_address[`ADDR_HI_MSB:`ADDR_HI_LSB]);
  assign o_match_low  = (i_byte == i_address);

endmodule

`default_nettype wire

// ---- src/i2c_slave_addr_receive.v ----
// Slave side of a two-wire serial port: bus conditions, address match,
// receive with acknowledge control, clock stretching and a basic send path.
// Assumes open-drain pads outside; all control and status bits are plain ports.
`timescale 1ns/100ps
`default_nettype none

`include "i2c_slave_consts.vh"

// Contract
// - SDA falling while SCL high is a Start; bus becomes active.
// - Flag a collision when SDA reads low before we would drive it low; code flags it only while sending, when a released SDA reads low.
// - SDA rising while SCL high is a Stop, only after an SCL low.
// - Restart resets slave logic like Start and awaits a new address.
// - 10-bit read needs Restart plus high byte with read; slave stretches.
// - Prior-match flag held after full 10-bit write match until cleared.
// - Start/stop interrupt enables add interrupts only in modes lacking them.
// - Ninth clock is the acknowledge slot; receiver pulls SDA low.
// - Acknowledge level from the bus is stored in ack-received.
// - No holds means automatic ack; holds mean ack from ack-value bit.
// - Not-acknowledge while buffer-full or overflow; overwrite enable modifies.
// - Ack-time flag set after eighth fall when addressed and holds enabled.
// - Mode field picks 7/10-bit, with or without start/stop interrupts.
// - First byte compared to address; match loads buffer and interrupts.
// - 7-bit matching ignores the address byte's least significant bit.
// - 10-bit high byte compared with 11110, A9, A8 from address bits.
// - Update-address flag set after each 10-bit address byte; write clears. Code sets it only after an acked write high byte and any low byte.
// - Matching write address clears read/write, loads buffer, acknowledges.
// - Interrupt flag raised per byte; software clears it.
// - With stretch enable, hold SCL after each received byte until release.
// - Start sets start-seen, Stop sets stop-seen; buffer read clears full.
// - SDA changes only while SCL low; sampled on SCL rising edge.
// - Bytes shifted most significant bit first.
module i2c_slave_addr_receive (
  input  wire                i_ref_clk,
  input  wire                i_srst,
  input  wire                i_scl,
  input  wire                i_sda,
  input  wire [`MODE_W-1:0]  i_port_mode_select,
  input  wire [7:0]          i_slave_address,
  input  wire                i_address_write,
  input  wire                i_stretch_enable,
  input  wire                i_clock_release,
  input  wire                i_address_hold_enable,
  input  wire                i_data_hold_enable,
  input  wire                i_ack_value_select,
  input  wire                i_buffer_overwrite_enable,
  input  wire                i_start_irq_enable,
  input  wire                i_stop_irq_enable,
  input  wire                i_buffer_read,
  input  wire                i_irq_clear,
  input  wire                i_overflow_clear,
  input  wire                i_collision_clear,
  input  wire                i_tx_load,
  input  wire [7:0]          i_tx_data,
  output reg                 o_scl_out,
  output reg                 o_scl_oe,
  output reg                 o_sda_out,
  output reg                 o_sda_oe,
  output reg  [7:0]          o_rx_tx_buffer,
  output reg                 o_buffer_full,
  output reg                 o_receive_overflow,
  output reg                 o_read_write,
  output reg                 o_data_not_address,
  output reg                 o_start_seen,
  output reg                 o_stop_seen,
  output reg                 o_ack_received,
  output reg                 o_ack_time_flag,
  output reg                 o_update_address_flag,
  output reg                 o_clock_release,
  output reg                 o_port_irq_flag,
  output reg                 o_bus_collision,
  output reg                 o_prior_match
);

  // One-hot protocol states
  localparam [4:0] ST_IDLE     = 5'h01;
  localparam [4:0] ST_ADDR     = 5'h02;
  localparam [4:0] ST_ADDR_LOW = 5'h04;
  localparam [4:0] ST_RX       = 5'h08;
  localparam [4:0] ST_TX       = 5'h10;

  wire scl_level;
  wire sda_level;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire match_7bit;
  wire match_high;
  wire match_low;
  wire byte_read;

  reg [4:0]        state_reg;
  reg [`CNT_W-1:0] bit_cnt_reg;
  reg [7:0]        shift_reg;
  reg [7:0]        tx_shift_reg;
  reg              scl_low_seen_reg;
  reg              ack_pending_reg;
  reg              hold_active_reg;
  reg              ua_hold_reg;

  pin_sync u_pin_sync (
    .i_ref_clk   (i_ref_clk),
    .i_srst      (i_srst),
    .i_scl       (i_scl),
    .i_sda       (i_sda),
    .o_scl_level (scl_level),
    .o_sda_level (sda_level),
    .o_scl_rise  (scl_rise),
    .o_scl_fall  (scl_fall),
    .o_start     (start_det),
    .o_stop      (stop_det)
  );

  addr_match u_addr_match (
    .i_byte       (shift_reg),
    .i_address    (i_slave_address),
    .o_match_7bit (match_7bit),
    .o_match_high (match_high),
    .o_match_low  (match_low),
    .o_read       (byte_read)
  );

  // Mode decode and byte-complete decisions
  wire ten_bit   = i_port_mode_select[`MODE_TEN_BIT_BIT];
  wire int_mode  = i_port_mode_select[`MODE_INT_BIT];
  wire in_addr   = (state_reg == ST_ADDR);
  wire in_low    = (state_reg == ST_ADDR_LOW);
  wire in_rx     = (state_reg == ST_RX);
  wire in_tx     = (state_reg == ST_TX);
  wire byte_fall = scl_fall & scl_low_seen_reg & (bit_cnt_reg == `CNT_LAST_DATA);
  wire ack_fall  = scl_fall & scl_low_seen_reg & (bit_cnt_reg == `CNT_ACK_SLOT);
  // A 10-bit read high byte only counts after a full write match
  wire addr_hit  = ten_bit ? (match_high & (~byte_read | o_prior_match)) : match_7bit;
  wire accept    = (in_addr & addr_hit) | (in_low & match_low) | in_rx;
  // Overwrite enable lets a full buffer be replaced rather than refused
  wire blocked   = o_receive_overflow | (o_buffer_full & ~i_buffer_overwrite_enable);
  wire hold_en   = (in_addr | in_low) ? i_address_hold_enable : i_data_hold_enable;
  // Ack follows software only while a hold is in force
  wire ack_drive = ack_pending_reg & (~hold_active_reg | ~i_ack_value_select);
  wire start_irq = int_mode | i_start_irq_enable;
  wire stop_irq  = int_mode | i_stop_irq_enable;

  // Pin drivers: outputs are always low, only the enables move
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_scl_out <= 1'h0;
      o_sda_out <= 1'h0;
      o_scl_oe  <= 1'h0;
      o_sda_oe  <= 1'h0;
    end else begin
      o_scl_out <= 1'h0;
      o_sda_out <= 1'h0;
      o_scl_oe  <= ~o_clock_release | ua_hold_reg;
      o_sda_oe  <= ((in_addr | in_low | in_rx) & (bit_cnt_reg == `CNT_ACK_SLOT) & ack_drive) |
                   (in_tx & (bit_cnt_reg < `CNT_ACK_SLOT) & ~tx_shift_reg[7]);
    end
  end

  // Protocol engine; one cycle lag to the pins is tiny against the bus clock
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_reg             <= ST_IDLE;
      bit_cnt_reg           <= 4'h0;
      shift_reg             <= `RST_BYTE;
      tx_shift_reg          <= 8'hff;
      scl_low_seen_reg      <= 1'h0;
      ack_pending_reg       <= 1'h0;
      hold_active_reg       <= 1'h0;
      ua_hold_reg           <= 1'h0;
      o_rx_tx_buffer        <= `RST_BYTE;
      o_buffer_full         <= 1'h0;
      o_receive_overflow    <= 1'h0;
      o_read_write          <= 1'h0;
      o_data_not_address    <= 1'h0;
      o_start_seen          <= 1'h0;
      o_stop_seen           <= 1'h0;
      o_ack_received        <= 1'h0;
      o_ack_time_flag       <= 1'h0;
      o_update_address_flag <= 1'h0;
      o_clock_release       <= `RST_CLOCK_RELEASE;
      o_port_irq_flag       <= 1'h0;
      o_bus_collision       <= 1'h0;
      o_prior_match         <= 1'h0;
    end else begin
      // Software clears first; any hardware set below overrides them
      if (i_irq_clear)
        o_port_irq_flag <= 1'h0;
      if (i_buffer_read)
        o_buffer_full <= 1'h0;
      if (i_overflow_clear)
        o_receive_overflow <= 1'h0;
      if (i_collision_clear)
        o_bus_collision <= 1'h0;
      if (i_clock_release)
        o_clock_release <= 1'h1;
      if (i_address_write) begin
        o_update_address_flag <= 1'h0;
        ua_hold_reg           <= 1'h0;
      end
      // Loading send data is only meaningful once a read is under way
      if (i_tx_load) begin
        tx_shift_reg   <= i_tx_data;
        o_rx_tx_buffer <= i_tx_data;
        o_buffer_full  <= 1'h1;
      end

      if (start_det) begin
        // Start and Restart share one path back to address reception
        state_reg        <= ST_ADDR;
        bit_cnt_reg      <= 4'h0;
        scl_low_seen_reg <= 1'h0;
        ack_pending_reg  <= 1'h0;
        hold_active_reg  <= 1'h0;
        o_ack_time_flag  <= 1'h0;
        tx_shift_reg     <= 8'hff;
        o_start_seen     <= 1'h1;
        o_stop_seen      <= 1'h0;
        if (start_irq)
          o_port_irq_flag <= 1'h1;
      end else if (stop_det & scl_low_seen_reg) begin
        // A Stop with no SCL low since the Start is not a Stop
        state_reg       <= ST_IDLE;
        ack_pending_reg <= 1'h0;
        hold_active_reg <= 1'h0;
        o_ack_time_flag <= 1'h0;
        tx_shift_reg    <= 8'hff;
        o_stop_seen     <= 1'h1;
        o_start_seen    <= 1'h0;
        o_prior_match   <= 1'h0;
        if (stop_irq)
          o_port_irq_flag <= 1'h1;
      end else if (state_reg != ST_IDLE) begin
        // Data is taken on the rising edge, most significant bit first
        if (scl_rise & scl_low_seen_reg & (bit_cnt_reg < `CNT_ACK_SLOT)) begin
          shift_reg <= {shift_reg[6:0], sda_level};
          // Released line reads low: someone else owns it
          if (in_tx & tx_shift_reg[7] & ~sda_level) begin
            o_bus_collision <= 1'h1;
            state_reg       <= ST_IDLE;
            tx_shift_reg    <= 8'hff;
          end
        end
        if (scl_rise & scl_low_seen_reg & (bit_cnt_reg == `CNT_ACK_SLOT) & in_tx)
          o_ack_received <= sda_level;

        if (scl_fall) begin
          // The fall just after Start opens the first bit's low time
          if (!scl_low_seen_reg)
            scl_low_seen_reg <= 1'h1;
          else if (bit_cnt_reg == `CNT_ACK_SLOT)
            bit_cnt_reg <= 4'h0;
          else
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (in_tx & scl_low_seen_reg & (bit_cnt_reg < `CNT_LAST_DATA))
            tx_shift_reg <= {tx_shift_reg[6:0], 1'h1};
        end

        // Eighth fall: decide acknowledge and whether software holds it
        if (byte_fall & ~in_tx) begin
          if (in_addr & ~addr_hit) begin
            state_reg <= ST_IDLE;
            if (ten_bit)
              o_prior_match <= 1'h0;
          end else begin
            ack_pending_reg <= accept & ~blocked;
            hold_active_reg <= accept & hold_en;
            if (in_addr & ten_bit & ~byte_read)
              o_prior_match <= 1'h0;
            if (in_addr) begin
              o_read_write       <= byte_read;
              o_data_not_address <= 1'h0;
            end else if (in_rx)
              o_data_not_address <= 1'h1;
            if (accept & (~o_buffer_full | i_buffer_overwrite_enable) & ~o_receive_overflow) begin
              o_rx_tx_buffer <= shift_reg;
              o_buffer_full  <= 1'h1;
            end
            if (accept & o_buffer_full)
              o_receive_overflow <= 1'h1;
            if (accept & hold_en) begin
              o_ack_time_flag <= 1'h1;
              o_port_irq_flag <= 1'h1;
              o_clock_release <= 1'h0;
            end
          end
        end
        if (byte_fall & in_tx)
          tx_shift_reg <= 8'hff;

        // Ninth fall: end of the acknowledge slot
        if (ack_fall) begin
          o_ack_time_flag <= 1'h0;
          ack_pending_reg <= 1'h0;
          hold_active_reg <= 1'h0;
          case (state_reg)
            ST_ADDR: begin
              if (!ack_drive)
                state_reg <= ST_IDLE;
              else begin
                o_port_irq_flag <= 1'h1;
                if (o_read_write) begin
                  state_reg       <= ST_TX;
                  o_clock_release <= 1'h0;
                end else if (ten_bit) begin
                  state_reg             <= ST_ADDR_LOW;
                  o_update_address_flag <= 1'h1;
                  ua_hold_reg           <= 1'h1;
                end else begin
                  state_reg <= ST_RX;
                  if (i_stretch_enable)
                    o_clock_release <= 1'h0;
                end
              end
            end
            ST_ADDR_LOW: begin
              // Flag and stretch whether or not the low byte matched
              o_update_address_flag <= 1'h1;
              ua_hold_reg           <= 1'h1;
              o_port_irq_flag       <= 1'h1;
              if (ack_drive) begin
                state_reg     <= ST_RX;
                o_prior_match <= 1'h1;
                if (i_stretch_enable)
                  o_clock_release <= 1'h0;
              end else
                state_reg <= ST_IDLE;
            end
            ST_RX: begin
              if (ack_drive) begin
                o_port_irq_flag <= 1'h1;
                if (i_stretch_enable)
                  o_clock_release <= 1'h0;
              end else
                state_reg <= ST_IDLE;
            end
            ST_TX: begin
              // Master not-ack ends the read without holding the clock
              o_port_irq_flag <= 1'h1;
              if (o_ack_received)
                state_reg <= ST_IDLE;
              else
                o_clock_release <= 1'h0;
            end
            default: begin
              state_reg <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- src/i2c_slave_consts.vh ----
// Shared constants for the serial-port slave receiver.
// Assumes it is included by bare name from every design file except the pin synchroniser, which does not include it.
`ifndef I2C_SLAVE_CONSTS_VH
`define I2C_SLAVE_CONSTS_VH

// Port mode field: bit 0 picks 10-bit addressing, bit 1 adds start/stop interrupts
`define MODE_W            2
`define MODE_TEN_BIT_BIT  0
`define MODE_INT_BIT      1

// Bit counter positions within a nine-clock segment
`define CNT_W             4
`define CNT_LAST_DATA     4'h7
`define CNT_ACK_SLOT      4'h8

// High address byte pattern for 10-bit addressing, bits 7..3
`define TEN_BIT_PATTERN   5'h1e
`define ADDR_HI_MSB       2
`define ADDR_HI_LSB       1

// Reset values
`define RST_BYTE          8'h00
`define RST_CLOCK_RELEASE 1'h1

`endif

// ---- src/pin_sync.v ----
// Two-stage synchroniser for the clock and data pins plus bus-condition detection.
// Assumes both pins are asynchronous to i_ref_clk and far slower than it.
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
  input  wire i_ref_clk,
  input  wire i_srst,
  input  wire i_scl,
  input  wire i_sda,
  output wire o_scl_level,
  output wire o_sda_level,
  output wire o_scl_rise,
  output wire o_scl_fall,
  output wire o_start,
  output wire o_stop
);

  reg scl_meta_reg;
  reg scl_sync_reg;
  reg scl_prev_reg;
  reg sda_meta_reg;
  reg sda_sync_reg;
  reg sda_prev_reg;

  // Meta stages feed only the sync stages; the idle bus reads high
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      scl_meta_reg <= 1'h1;
      scl_sync_reg <= 1'h1;
      scl_prev_reg <= 1'h1;
      sda_meta_reg <= 1'h1;
      sda_sync_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end else begin
      scl_meta_reg <= i_scl;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= i_sda;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // Edges and conditions from the synchronised copies only
  assign o_scl_level = scl_sync_reg;
  assign o_sda_level = sda_sync_reg;
  assign o_scl_rise  = scl_sync_reg & ~scl_prev_reg;
  assign o_scl_fall  = ~scl_sync_reg & scl_prev_reg;
  assign o_start     = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign o_stop      = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

endmodule

`default_nettype wire
